/* File: hdl/aud_top.v */
// Register side of the audio controller: DMA ring registers, status flags,
// serial audio clock control and codec link control over AXI4-Lite.
// Assumes DMA beats, FIFO levels and link events arrive on aclk.
//
// Contract
// - Record base address register, CPU read/write
// - Record buffer length register, CPU read/write
// - Record current address, read only
// - Record status reports FIFO full
// - Record end flag, write one clears
// - Record middle flag, write one clears
// - Playback base address register, CPU read/write
// - Playback buffer length register, CPU read/write
// - Playback current address, read only
// - Playback FIFO empty bit, resets set; code reads the play_fifo_empty input as is and loads no reset value of its own
// - Playback end flag, write one clears
// - Playback middle flag, write one clears
// - Prescaler code divides PLL into master clock
// - Odd factors give short master high
// - Source bit picks prescaled or PLL clock
// - Ratio bit picks fs at 256 or 384; code honours it only at bit clock select 00, 48 per sample is always 384
// - Bit clock select: 32 or 48 per sample
// - Format bit: standard or MSB-justified framing
// - Link control layout bits five to one
// - Cold reset bit drives codec reset low
// - Warm reset forces sync high, self clears
// - Write pending set on slot0 write, cleared sent
// - Read ready set on slot2 load, cleared read
`timescale 1ns/1ps
module aud_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        rec_dma_beat,
    input  wire        play_dma_beat,
    input  wire        rec_fifo_full,
    input  wire        play_fifo_empty,
    input  wire        link_frame_sync,
    input  wire        link_slot0_sent,
    input  wire        link_slot2_loaded,
    input  wire [15:0] link_slot2_data,
    output wire [31:0] rec_dma_addr,
    output wire [31:0] play_dma_addr,
    output reg         rec_irq,
    output reg         play_irq,
    output wire        mclk_pin,
    output wire        bclk_pin,
    output wire        lrclk_pin,
    output wire        frame_tick,
    output reg         codec_reset_n_pin,
    output reg         link_sync_pin,
    output reg         link_bitclk_pullup,
    output reg  [4:0]  out_slot0_data,
    output reg         link_write_pending
);
`include "aud_defines.vh"

    localparam [1:0] RESP_OKAY   = 2'b00;
    localparam [1:0] RESP_SLVERR = 2'b10;
    localparam [31:0] WARM_LAST  = `AUD_WARM_CYCLES - 1;

    // Warm reset sequencer states, one-hot
    localparam [1:0] WS_IDLE = 2'b01;
    localparam [1:0] WS_HOLD = 2'b10;

    // Bus capture
    reg  [31:0] aw_addr_reg;
    reg         aw_held_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         w_held_reg;

    // Software registers
    reg  [31:0] rec_base_addr;
    reg  [31:0] rec_buf_len;
    reg  [31:0] play_base_addr;
    reg  [31:0] play_buf_len;
    reg  [31:0] ser_ctrl_reg;
    reg         rec_end_reg;
    reg         rec_mid_reg;
    reg         play_end_reg;
    reg         play_mid_reg;
    reg         link_cold_reset;
    reg         link_warm_reset;
    reg         link_read_ready;
    reg  [15:0] in_slot2_reg;
    reg  [1:0]  warm_state_reg;
    reg  [11:0] warm_cnt_reg;

    wire [31:0] rec_cur_addr;
    wire [31:0] play_cur_addr;
    wire        rec_mid_hit;
    wire        rec_end_hit;
    wire        play_mid_hit;
    wire        play_end_hit;
    wire        wr_go;
    wire        rd_go;
    wire        wr_hit;
    wire [31:0] wmask;
    reg  [31:0] rd_val;
    reg         rd_ok;
    wire        warm_done;

    // Write happens once address and data are both held
    assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                    {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    assign wr_hit = (aw_addr_reg == `AUD_REC_BASE_ADDR)  ||
                    (aw_addr_reg == `AUD_REC_LEN_ADDR)   ||
                    (aw_addr_reg == `AUD_REC_CUR_ADDR)   ||
                    (aw_addr_reg == `AUD_REC_STAT_ADDR)  ||
                    (aw_addr_reg == `AUD_PLAY_BASE_ADDR) ||
                    (aw_addr_reg == `AUD_PLAY_LEN_ADDR)  ||
                    (aw_addr_reg == `AUD_PLAY_CUR_ADDR)  ||
                    (aw_addr_reg == `AUD_PLAY_STAT_ADDR) ||
                    (aw_addr_reg == `AUD_SER_CTRL_ADDR)  ||
                    (aw_addr_reg == `AUD_LINK_CTRL_ADDR) ||
                    (aw_addr_reg == `AUD_OUT_SLOT0_ADDR) ||
                    (aw_addr_reg == `AUD_IN_SLOT2_ADDR);
    assign warm_done = (warm_state_reg == WS_HOLD) && (warm_cnt_reg == WARM_LAST[11:0]);

    // Write address and data channels, taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_reg   <= 32'h00000000;
            aw_held_reg   <= 1'b0;
            w_data_reg    <= 32'h00000000;
            w_strb_reg    <= 4'h0;
            w_held_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_held_reg <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_held_reg <= 1'b1;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_held_reg   <= 1'b0;
                w_held_reg    <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Plain read/write registers with byte strobes
    always @(posedge aclk) begin
        if (!aresetn) begin
            rec_base_addr  <= 32'h00000000;
            rec_buf_len    <= 32'h00000000;
            play_base_addr <= 32'h00000000;
            play_buf_len   <= 32'h00000000;
            ser_ctrl_reg   <= 32'h00000000;
            out_slot0_data <= 5'h00;
            link_bitclk_pullup <= 1'b0;
            link_cold_reset    <= 1'b0;
        end else if (wr_go) begin
            case (aw_addr_reg)
                `AUD_REC_BASE_ADDR:
                    rec_base_addr <= (rec_base_addr & ~wmask) | (w_data_reg & wmask);
                `AUD_REC_LEN_ADDR:
                    rec_buf_len <= (rec_buf_len & ~wmask) | (w_data_reg & wmask);
                `AUD_PLAY_BASE_ADDR:
                    play_base_addr <= (play_base_addr & ~wmask) | (w_data_reg & wmask);
                `AUD_PLAY_LEN_ADDR:
                    play_buf_len <= (play_buf_len & ~wmask) | (w_data_reg & wmask);
                `AUD_SER_CTRL_ADDR: begin
                    // Only the documented fields are kept
                    if (w_strb_reg[2])
                        ser_ctrl_reg[19:16] <= w_data_reg[19:16];
                    if (w_strb_reg[0])
                        ser_ctrl_reg[7:3] <= w_data_reg[7:3];
                end
                `AUD_LINK_CTRL_ADDR: begin
                    if (w_strb_reg[0]) begin
                        link_bitclk_pullup <= w_data_reg[`AUD_LC_PULLUP];
                        link_cold_reset    <= w_data_reg[`AUD_LC_COLD];
                    end
                end
                `AUD_OUT_SLOT0_ADDR: begin
                    // Writes while pending are dropped
                    if (w_strb_reg[0] && !link_write_pending)
                        out_slot0_data <= w_data_reg[4:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Sticky DMA flags; hardware set wins over write-one-clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            rec_end_reg  <= 1'b0;
            rec_mid_reg  <= 1'b0;
            play_end_reg <= 1'b0;
            play_mid_reg <= 1'b0;
        end else begin
            if (rec_end_hit)
                rec_end_reg <= 1'b1;
            else if (wr_go && aw_addr_reg == `AUD_REC_STAT_ADDR && w_strb_reg[0]
                     && w_data_reg[`AUD_ST_END])
                rec_end_reg <= 1'b0;
            if (rec_mid_hit)
                rec_mid_reg <= 1'b1;
            else if (wr_go && aw_addr_reg == `AUD_REC_STAT_ADDR && w_strb_reg[0]
                     && w_data_reg[`AUD_ST_MID])
                rec_mid_reg <= 1'b0;
            if (play_end_hit)
                play_end_reg <= 1'b1;
            else if (wr_go && aw_addr_reg == `AUD_PLAY_STAT_ADDR && w_strb_reg[0]
                     && w_data_reg[`AUD_ST_END])
                play_end_reg <= 1'b0;
            if (play_mid_hit)
                play_mid_reg <= 1'b1;
            else if (wr_go && aw_addr_reg == `AUD_PLAY_STAT_ADDR && w_strb_reg[0]
                     && w_data_reg[`AUD_ST_MID])
                play_mid_reg <= 1'b0;
        end
    end

    // Interrupt requests per direction
    always @(posedge aclk) begin
        if (!aresetn) begin
            rec_irq  <= 1'b0;
            play_irq <= 1'b0;
        end else begin
            rec_irq  <= rec_end_reg || rec_mid_reg;
            play_irq <= play_end_reg || play_mid_reg;
        end
    end

    // Link handshake flags; set wins over clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            link_write_pending <= 1'b0;
            link_read_ready    <= 1'b0;
            in_slot2_reg       <= 16'h0000;
        end else begin
            if (wr_go && aw_addr_reg == `AUD_OUT_SLOT0_ADDR && w_strb_reg[0]
                && !link_write_pending)
                link_write_pending <= 1'b1;
            else if (link_slot0_sent)
                link_write_pending <= 1'b0;
            if (link_slot2_loaded) begin
                link_read_ready <= 1'b1;
                in_slot2_reg    <= link_slot2_data;
            end else if (rd_go && s_axi_araddr == `AUD_IN_SLOT2_ADDR) begin
                link_read_ready <= 1'b0;
            end
        end
    end

    // Warm reset: hold sync high for the timed interval, then self-clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            warm_state_reg  <= WS_IDLE;
            warm_cnt_reg    <= 12'd0;
            link_warm_reset <= 1'b0;
        end else begin
            case (warm_state_reg)
                WS_IDLE: begin
                    warm_cnt_reg <= 12'd0;
                    if (wr_go && aw_addr_reg == `AUD_LINK_CTRL_ADDR && w_strb_reg[0]
                        && w_data_reg[`AUD_LC_WARM]) begin
                        link_warm_reset <= 1'b1;
                        warm_state_reg  <= WS_HOLD;
                    end
                end
                WS_HOLD: begin
                    warm_cnt_reg <= warm_cnt_reg + 12'd1;
                    if (warm_done) begin
                        link_warm_reset <= 1'b0;
                        warm_state_reg  <= WS_IDLE;
                    end
                end
                default: begin
                    warm_state_reg  <= WS_IDLE;
                    link_warm_reset <= 1'b0;
                end
            endcase
        end
    end

    // Codec pins
    always @(posedge aclk) begin
        if (!aresetn) begin
            codec_reset_n_pin <= 1'b1;
            link_sync_pin     <= 1'b0;
        end else begin
            codec_reset_n_pin <= !link_cold_reset;
            link_sync_pin     <= link_warm_reset || link_frame_sync;
        end
    end

    // Read data selection
    always @* begin
        rd_val = 32'h00000000;
        rd_ok  = 1'b1;
        case (s_axi_araddr)
            `AUD_REC_BASE_ADDR:  rd_val = rec_base_addr;
            `AUD_REC_LEN_ADDR:   rd_val = rec_buf_len;
            `AUD_REC_CUR_ADDR:   rd_val = rec_cur_addr;
            `AUD_REC_STAT_ADDR:
                rd_val = {29'h0, rec_fifo_full, rec_end_reg, rec_mid_reg};
            `AUD_PLAY_BASE_ADDR: rd_val = play_base_addr;
            `AUD_PLAY_LEN_ADDR:  rd_val = play_buf_len;
            `AUD_PLAY_CUR_ADDR:  rd_val = play_cur_addr;
            `AUD_PLAY_STAT_ADDR:
                rd_val = {29'h0, play_fifo_empty, play_end_reg, play_mid_reg};
            `AUD_SER_CTRL_ADDR:  rd_val = ser_ctrl_reg;
            `AUD_LINK_CTRL_ADDR:
                rd_val = {26'h0, link_bitclk_pullup, link_read_ready,
                          link_write_pending, link_warm_reset, link_cold_reset, 1'b0};
            `AUD_OUT_SLOT0_ADDR: rd_val = {27'h0, out_slot0_data};
            `AUD_IN_SLOT2_ADDR:  rd_val = {16'h0, in_slot2_reg};
            default:             rd_ok = 1'b0;
        endcase
    end

    // Read channel, one beat a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Record ring counter, reloaded on base write
    aud_ring u_rec_ring (
        .clk     (aclk),
        .rst_n   (aresetn),
        .load    (wr_go && aw_addr_reg == `AUD_REC_BASE_ADDR),
        .base    (rec_base_addr),
        .len     (rec_buf_len),
        .beat    (rec_dma_beat),
        .cur_reg (rec_cur_addr),
        .mid_reg (rec_mid_hit),
        .end_reg (rec_end_hit)
    );

    // Playback ring counter
    aud_ring u_play_ring (
        .clk     (aclk),
        .rst_n   (aresetn),
        .load    (wr_go && aw_addr_reg == `AUD_PLAY_BASE_ADDR),
        .base    (play_base_addr),
        .len     (play_buf_len),
        .beat    (play_dma_beat),
        .cur_reg (play_cur_addr),
        .mid_reg (play_mid_hit),
        .end_reg (play_end_hit)
    );

    assign rec_dma_addr  = rec_cur_addr;
    assign play_dma_addr = play_cur_addr;

    // Serial audio clocks; 48 per sample divides by 8, giving 384 fs whatever the ratio bit
    aud_clkgen u_clkgen (
        .clk            (aclk),
        .rst_n          (aresetn),
        .prescale       (ser_ctrl_reg[`AUD_SC_PRS_MSB:`AUD_SC_PRS_LSB]),
        .src_pll        (ser_ctrl_reg[`AUD_SC_MSRC]),
        .ratio384       (ser_ctrl_reg[`AUD_SC_RATIO]),
        .bclk_sel       (ser_ctrl_reg[`AUD_SC_BCLK_MSB:`AUD_SC_BCLK_LSB]),
        .msb_just       (ser_ctrl_reg[`AUD_SC_FMT]),
        .mclk_reg       (mclk_pin),
        .bclk_reg       (bclk_pin),
        .lrclk_reg      (lrclk_pin),
        .frame_tick_reg (frame_tick)
    );

endmodule

/* File: hdl/aud_defines.vh */
// Constants for the audio DMA status and serial clocking block.
// Assumes a 250 MHz system clock and byte addresses on an AXI4-Lite bus.
`ifndef AUD_DEFINES_VH
`define AUD_DEFINES_VH

// Register byte addresses
`define AUD_REC_BASE_ADDR    32'hfff09008
`define AUD_REC_LEN_ADDR     32'hfff0900c
`define AUD_REC_CUR_ADDR     32'hfff09010
`define AUD_REC_STAT_ADDR    32'hfff09014
`define AUD_PLAY_BASE_ADDR   32'hfff09018
`define AUD_PLAY_LEN_ADDR    32'hfff0901c
`define AUD_PLAY_CUR_ADDR    32'hfff09020
`define AUD_PLAY_STAT_ADDR   32'hfff09024
`define AUD_SER_CTRL_ADDR    32'hfff09028
`define AUD_LINK_CTRL_ADDR   32'hfff0902c
`define AUD_OUT_SLOT0_ADDR   32'hfff09030
`define AUD_IN_SLOT2_ADDR    32'hfff09044

// Reset values
`define AUD_PLAY_STAT_RST    32'h00000004

// Status register fields
`define AUD_ST_MID           0
`define AUD_ST_END           1
`define AUD_ST_FIFO          2

// Serial audio control fields
`define AUD_SC_PRS_LSB       16
`define AUD_SC_PRS_MSB       19
`define AUD_SC_BCLK_LSB      6
`define AUD_SC_BCLK_MSB      7
`define AUD_SC_RATIO         5
`define AUD_SC_MSRC          4
`define AUD_SC_FMT           3

// Codec link control fields
`define AUD_LC_PULLUP        5
`define AUD_LC_RDRDY         4
`define AUD_LC_WRPEND        3
`define AUD_LC_WARM          2
`define AUD_LC_COLD          1

// Timing: warm reset sync pulse
`define AUD_CLK_PERIOD_PS    4000
`define AUD_WARM_TIME_US     10
`define AUD_WARM_CYCLES      ((`AUD_WARM_TIME_US * 1000000 + `AUD_CLK_PERIOD_PS - 1) / `AUD_CLK_PERIOD_PS)

// DMA address step per beat, bytes
`define AUD_DMA_STEP         32'h00000004

`endif

/* File: hdl/aud_ring.v */
// Ring address counter for one DMA direction with midpoint and end events.
// Assumes beat pulses on the system clock; base load comes from a bus write.
`timescale 1ns/1ps
module aud_ring (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        load,
    input  wire [31:0] base,
    input  wire [31:0] len,
    input  wire        beat,
    output reg  [31:0] cur_reg,
    output reg         mid_reg,
    output reg         end_reg
);
`include "aud_defines.vh"

    wire [31:0] step_addr;
    wire [31:0] end_addr;
    wire [31:0] mid_addr;
    reg         load_dly_reg;

    // Next address and the two marks inside the buffer
    assign step_addr = cur_reg + `AUD_DMA_STEP;
    assign end_addr  = base + len;
    assign mid_addr  = base + {1'b0, len[31:1]};

    // Advance, flag marks once per crossing, wrap at the end
    always @(posedge clk) begin
        if (!rst_n) begin
            cur_reg <= 32'h00000000;
            mid_reg <= 1'b0;
            end_reg <= 1'b0;
            load_dly_reg <= 1'b0;
        end else begin
            mid_reg <= 1'b0;
            end_reg <= 1'b0;
            load_dly_reg <= load; // Fresh base first
            if (load_dly_reg) begin
                cur_reg <= base;
            end else if (beat) begin
                if (step_addr >= end_addr) begin
                    cur_reg <= base;
                    end_reg <= 1'b1;
                end else begin
                    cur_reg <= step_addr;
                    mid_reg <= (step_addr == mid_addr);
                end
            end
        end
    end

endmodule

/* File: hdl/aud_clkgen.v */
// Master, bit and frame clock generator for the serial audio port.
// Assumes the system clock stands in for the PLL input clock.
`timescale 1ns/1ps
module aud_clkgen (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [3:0] prescale,
    input  wire       src_pll,
    input  wire       ratio384,
    input  wire [1:0] bclk_sel,
    input  wire       msb_just,
    output reg        mclk_reg,
    output reg        bclk_reg,
    output reg        lrclk_reg,
    output reg        frame_tick_reg
);

    reg  [4:0] pre_cnt_reg;
    reg  [3:0] mc_cnt_reg;
    reg  [5:0] bit_cnt_reg;
    wire [4:0] factor;
    wire [3:0] bdiv;
    wire [5:0] bps;
    wire       mclk_tick;
    wire       bit_tick;
    wire [5:0] lr_pos;

    // Divider settings
    assign factor    = src_pll ? 5'd1 : ({1'b0, prescale} + 5'd1);
    assign bdiv      = (ratio384 && bclk_sel == 2'b00) ? 4'd12 : 4'd8;
    assign bps       = (bclk_sel == 2'b01) ? 6'd48 : 6'd32;
    assign mclk_tick = (pre_cnt_reg == 5'd0);
    assign bit_tick  = mclk_tick && (mc_cnt_reg == bdiv - 4'd1);
    assign lr_pos    = msb_just ? bit_cnt_reg :
                       ((bit_cnt_reg == bps - 6'd1) ? 6'd0 : bit_cnt_reg + 6'd1);

    // Counters and registered pin levels
    always @(posedge clk) begin
        if (!rst_n) begin
            pre_cnt_reg    <= 5'd0;
            mc_cnt_reg     <= 4'd0;
            bit_cnt_reg    <= 6'd0;
            mclk_reg       <= 1'b0;
            bclk_reg       <= 1'b0;
            lrclk_reg      <= 1'b0;
            frame_tick_reg <= 1'b0;
        end else begin
            pre_cnt_reg <= (pre_cnt_reg >= factor - 5'd1) ? 5'd0 : pre_cnt_reg + 5'd1;
            // Odd factors give a short high phase
            mclk_reg <= (factor == 5'd1) || (pre_cnt_reg < {1'b0, factor[4:1]});
            if (mclk_tick)
                mc_cnt_reg <= (mc_cnt_reg >= bdiv - 4'd1) ? 4'd0 : mc_cnt_reg + 4'd1;
            if (bit_tick)
                bit_cnt_reg <= (bit_cnt_reg >= bps - 6'd1) ? 6'd0 : bit_cnt_reg + 6'd1;
            bclk_reg       <= (mc_cnt_reg >= {1'b0, bdiv[3:1]});
            lrclk_reg      <= (lr_pos >= {1'b0, bps[5:1]});
            frame_tick_reg <= bit_tick && (bit_cnt_reg == bps - 6'd1);
        end
    end

endmodule

/* File: sim/aud_properties.sv */
// Checker on the ports of the audio register block.
// Assumes aclk with a synchronous active-low aresetn.
`timescale 1ns/1ps
module aud_properties (
    input wire        aclk, aresetn, s_axi_wvalid, rec_dma_beat, play_dma_beat,
    input wire        rec_irq, play_irq, link_frame_sync, link_sync_pin,
    input wire        link_slot0_sent, link_write_pending, codec_reset_n_pin, s_axi_bvalid,
    input wire [31:0] rec_dma_addr, play_dma_addr
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Ring addresses, status flags and link pins
    property p_rstep; rec_dma_beat |=> rec_dma_addr != $past(rec_dma_addr); endproperty
    a_rstep: assert property (p_rstep) else $error("rec addr stuck");
    property p_pstep; play_dma_beat |=> play_dma_addr != $past(play_dma_addr); endproperty
    a_pstep: assert property (p_pstep) else $error("play addr stuck");
    property p_rclr; $fell(rec_irq) |-> $past(s_axi_bvalid); endproperty
    a_rclr: assert property (p_rclr) else $error("rec irq fell alone");
    property p_pclr; $fell(play_irq) |-> $past(s_axi_bvalid); endproperty
    a_pclr: assert property (p_pclr) else $error("play irq fell alone");
    property p_sync; link_frame_sync |=> link_sync_pin; endproperty
    a_sync: assert property (p_sync) else $error("sync low");
    property p_sent; link_slot0_sent && !s_axi_wvalid |=> !link_write_pending; endproperty
    a_sent: assert property (p_sent) else $error("pending kept");
    property p_hold; link_write_pending && !link_slot0_sent |=> link_write_pending; endproperty
    a_hold: assert property (p_hold) else $error("pending lost");
    property p_cold; $rose(codec_reset_n_pin) |-> $past(s_axi_bvalid); endproperty
    a_cold: assert property (p_cold) else $error("reset pin rose alone");
endmodule
bind aud_top aud_properties chk (.*);

/* File: sim/aud_codec_model.sv */
// Codec on the far side of the link: sends slot 0 out, returns slot 2.
// Assumes it runs on aclk and sees the pending flag of the outgoing slot.
`timescale 1ns/1ps
module aud_codec_model #(
    parameter int LAT = 20
) (
    input  wire         aclk, link_write_pending, rd_req,
    output logic        link_slot0_sent = 0, link_slot2_loaded = 0, link_frame_sync = 0,
    output logic [15:0] link_slot2_data = 16'h0
);
    int cnt = 0;
    // Slot shifted out a while after it is pending; read data valid in load cycle only
    always @(posedge aclk) begin
        cnt <= link_write_pending ? cnt + 1 : 0;
        link_slot0_sent <= (cnt == LAT);
        link_frame_sync <= (cnt == 2);
        link_slot2_loaded <= rd_req;
        link_slot2_data <= rd_req ? 16'hbeef : ~link_slot2_data;
    end
endmodule

/* File: sim/tb.sv */
// Bench for the audio register block: register table, rings, flags, link.
// Assumes the codec model on the link side and a 250 MHz aclk.
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic [7:0] o; logic [31:0] d, e;} row_t;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, rec_dma_beat = 0, play_dma_beat = 0;
    logic rec_fifo_full = 0, play_fifo_empty = 1, rd_req = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] resp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rec_irq;
    wire play_irq, mclk_pin, bclk_pin, lrclk_pin, frame_tick, codec_reset_n_pin, link_sync_pin;
    wire link_bitclk_pullup, link_write_pending, link_frame_sync, link_slot0_sent;
    wire link_slot2_loaded;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [4:0] out_slot0_data;
    wire [15:0] link_slot2_data;
    wire [31:0] s_axi_rdata, rec_dma_addr, play_dma_addr;
    int failures = 0, num_checks = 0, n = 0;
    row_t rows[10] = '{'{8'h0c, 32'h10, 32'h10}, '{8'h08, 32'h1000, 32'h1000},
        '{8'h10, 32'h55, 32'h1000}, '{8'h1c, 32'h20, 32'h20},
        '{8'h18, 32'h2000, 32'h2000}, '{8'h20, 32'h7, 32'h2000},
        '{8'h24, 32'h0, 32'h4}, '{8'h28, 32'hfff5ff68, 32'h50068},
        '{8'h2c, 32'h20, 32'h20}, '{8'h50, 32'h1, 32'h0}};
    aud_top dut (.*);
    aud_codec_model cdc (.*);
    initial forever #2 aclk = ~aclk;
    initial begin #40000; failures++; stop_test; end
    task check(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin failures++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end
    endtask
    // Bus cycles: hold each channel until its ready is sampled
    task wr(input logic [7:0] o, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {24'hfff090, o, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask
    task rd(input logic [7:0] o, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= {24'hfff090, o};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        resp = s_axi_rresp;
        check("rdata", e, s_axi_rdata);
    endtask
    task beat(input bit p, input int k);
        repeat (k) begin
            @(posedge aclk);
            if (p) play_dma_beat <= 1; else rec_dma_beat <= 1;
            @(posedge aclk);
            {play_dma_beat, rec_dma_beat} <= 2'h0;
        end
        repeat (3) @(posedge aclk);
    endtask
    task stop_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rd(8'h08, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].o, rows[i].d);
            rd(rows[i].o, rows[i].e);
        end
        check("resp", 32'h2, 32'(resp));
        repeat (6) @(posedge aclk) n += mclk_pin;
        check("mclk", 32'h3, n);
        rec_fifo_full <= 1;
        beat(0, 2);
        rd(8'h14, 32'h5);
        beat(0, 2);
        rd(8'h14, 32'h7);
        check("rec addr", 32'h1000, rec_dma_addr);
        wr(8'h14, 32'h1);
        rd(8'h14, 32'h6);
        check("rec irq", 32'h1, 32'(rec_irq));
        wr(8'h14, 32'h2);
        rd(8'h14, 32'h4);
        check("rec irq", 32'h0, 32'(rec_irq));
        beat(1, 8);
        rd(8'h24, 32'h7);
        check("play irq", 32'h1, 32'(play_irq));
        wr(8'h24, 32'h3);
        wr(8'h2c, 32'h22);
        rd(8'h2c, 32'h22);
        check("cold", 32'h0, 32'(codec_reset_n_pin));
        wr(8'h2c, 32'h24);
        @(negedge aclk) check("sync", 32'h1, 32'(link_sync_pin));
        rd(8'h2c, 32'h24);
        repeat (2600) @(posedge aclk);
        rd(8'h2c, 32'h20);
        wr(8'h30, 32'h1f);
        rd(8'h2c, 32'h28);
        repeat (30) @(posedge aclk);
        rd(8'h2c, 32'h20);
        @(posedge aclk) rd_req <= 1;
        @(posedge aclk) rd_req <= 0;
        rd(8'h2c, 32'h30);
        rd(8'h44, 32'hbeef);
        rd(8'h2c, 32'h20);
        stop_test;
    end
endmodule
